//--- logic/motor_position_capture.sv
`timescale 1ns/1ps
module motor_position_capture (
	input  wire logic               i_clk_sys,           // 100 MHz system clock
	input  wire logic               i_rst,               // async reset, high
	input  wire logic               i_first_trigger_pin,  // capture input one
	input  wire logic               i_second_trigger_pin, // capture input two
	input  wire logic signed [31:0] i_motor_pos,         // live position, user units
	input  wire logic               i_ref_adjust,        // reference redefined pulse
	input  wire logic signed [31:0] i_ref_delta,         // new minus old reference
	input  wire logic [15:0]        i_par_addr,          // parameter address
	input  wire logic               i_par_wr,            // write request pulse
	input  wire logic               i_par_rd,            // read request pulse
	input  wire logic [31:0]        i_par_wdata,         // write data
	output logic [31:0]             o_par_rdata,         // read data
	output logic                    o_par_ack,           // answer pulse
	output logic                    o_par_err            // refused access pulse
);

	// ------------------------------------------------------------
	// legality checks on written values
	// ------------------------------------------------------------
	function automatic logic edge_val_ok(input logic [15:0] v);
		edge_val_ok = (v[15:1] == 15'h0000);
	endfunction

	function automatic logic mode_val_ok(input logic [15:0] v);
		mode_val_ok = (v <= capture_pkg::MODE_MAX);
	endfunction

	// ------------------------------------------------------------
	// stored configuration
	// ------------------------------------------------------------
	logic                   edge_one;
	logic                   edge_two;
	logic [15:0]            act_one;
	logic [15:0]            act_two;
	logic signed [31:0]     pos_one;
	logic signed [31:0]     pos_two;
	logic [15:0]            count_one;
	logic [15:0]            count_two;
	logic                   capt_one;
	logic                   capt_two;
	capture_pkg::cap_mode_t mode_one;
	capture_pkg::cap_mode_t mode_two;
	logic [31:0]            next_rdata;
	logic                   next_err;

	// address decode
	wire [15:0] wval     = i_par_wdata[15:0];
	wire        a_status = (i_par_addr == capture_pkg::STATUS_ADDR);
	wire        a_edge1  = (i_par_addr == capture_pkg::EDGE1_ADDR);
	wire        a_edge2  = (i_par_addr == capture_pkg::EDGE2_ADDR);
	wire        a_start1 = (i_par_addr == capture_pkg::START1_ADDR);
	wire        a_start2 = (i_par_addr == capture_pkg::START2_ADDR);
	wire        a_pos1   = (i_par_addr == capture_pkg::POS1_ADDR);
	wire        a_pos2   = (i_par_addr == capture_pkg::POS2_ADDR);
	wire        a_cnt1   = (i_par_addr == capture_pkg::COUNT1_ADDR);
	wire        a_cnt2   = (i_par_addr == capture_pkg::COUNT2_ADDR);
	wire        a_known  = a_status | a_edge1 | a_edge2 | a_start1 | a_start2
	                     | a_pos1 | a_pos2 | a_cnt1 | a_cnt2;

	// accepted writes; a write wins over a read in the same cycle
	wire wr_edge1  = i_par_wr & a_edge1 & edge_val_ok(wval);
	wire wr_edge2  = i_par_wr & a_edge2 & edge_val_ok(wval);
	wire wr_start1 = i_par_wr & a_start1 & mode_val_ok(wval);
	wire wr_start2 = i_par_wr & a_start2 & mode_val_ok(wval);
	wire wr_taken  = wr_edge1 | wr_edge2 | wr_start1 | wr_start2;
	wire rd_only   = i_par_rd & ~i_par_wr;

	// mode decode of the start/stop value
	wire capture_pkg::cap_mode_t start_mode = capture_pkg::cap_mode_t'(wval[1:0]);

	// status word bits
	wire [15:0] status_word = {14'h0000, capt_two, capt_one};

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// edge select takes effect on the next cycle's detection
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			edge_one <= capture_pkg::EDGE_RESET;
			edge_two <= capture_pkg::EDGE_RESET;
		end else begin
			if (wr_edge1)
				edge_one <= wval[0];
			if (wr_edge2)
				edge_two <= wval[0];
		end
	end

	// start/stop values read back as last written
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			act_one <= 16'h0000;
			act_two <= 16'h0000;
		end else begin
			if (wr_start1)
				act_one <= wval;
			if (wr_start2)
				act_two <= wval;
		end
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	// two identical independent channels, one pin each
	capture_channel u_chan_one (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (i_rst),
		.i_trig       (i_first_trigger_pin),
		.i_edge_rise  (edge_one),
		.i_start      (wr_start1),
		.i_start_mode (start_mode),
		.i_motor_pos  (i_motor_pos),
		.i_ref_adjust (i_ref_adjust),
		.i_ref_delta  (i_ref_delta),
		.o_pos        (pos_one),
		.o_count      (count_one),
		.o_captured   (capt_one),
		.o_mode       (mode_one)
	);

	capture_channel u_chan_two (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (i_rst),
		.i_trig       (i_second_trigger_pin),
		.i_edge_rise  (edge_two),
		.i_start      (wr_start2),
		.i_start_mode (start_mode),
		.i_motor_pos  (i_motor_pos),
		.i_ref_adjust (i_ref_adjust),
		.i_ref_delta  (i_ref_delta),
		.o_pos        (pos_two),
		.o_count      (count_two),
		.o_captured   (capt_two),
		.o_mode       (mode_two)
	);

	// ------------------------------------------------------------
	// answer path
	// ------------------------------------------------------------
	// read mux and refusal decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (i_par_wr) begin
			next_err = ~wr_taken;
		end else if (i_par_rd) begin
			next_err = ~a_known;
			if (a_status)
				next_rdata = {16'h0000, status_word};
			else if (a_edge1)
				next_rdata = {31'h0000_0000, edge_one};
			else if (a_edge2)
				next_rdata = {31'h0000_0000, edge_two};
			else if (a_start1)
				next_rdata = {16'h0000, act_one};
			else if (a_start2)
				next_rdata = {16'h0000, act_two};
			else if (a_pos1)
				next_rdata = pos_one;
			else if (a_pos2)
				next_rdata = pos_two;
			else if (a_cnt1)
				next_rdata = {16'h0000, count_one};
			else if (a_cnt2)
				next_rdata = {16'h0000, count_two};
		end
	end

	// registered answer, one cycle after the request
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_par_rdata <= 32'h0000_0000;
			o_par_ack   <= 1'b0;
			o_par_err   <= 1'b0;
		end else begin
			o_par_rdata <= next_rdata;
			o_par_ack   <= i_par_wr | i_par_rd;
			o_par_err   <= next_err;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	status_map_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rd_only && a_status)
		|=> (o_par_ack && o_par_rdata[1:0] == {$past(capt_two), $past(capt_one)}
		     && o_par_rdata[31:2] == 30'h0000_0000))
		else $error("status word does not show channel flags");

	mode_decode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(wr_start1 && wval == 16'h0002) |=> mode_one == capture_pkg::MODE_CONT
		##1 mode_one == capture_pkg::MODE_CONT || $past(wr_start1))
		else $error("continuous start not decoded");

	cancel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(wr_start2 && wval == 16'h0000) |=> mode_two == capture_pkg::MODE_STOP)
		else $error("cancel did not stop channel two");

	edge_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_edge1 |=> edge_one == $past(wval[0]))
		else $error("edge select not stored");

	bad_value_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_par_wr && a_start1 && wval > capture_pkg::MODE_MAX)
		|=> (o_par_err && $stable(act_one)))
		else $error("illegal start value accepted");

	unmapped_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rd_only && !a_known) |=> (o_par_ack && o_par_err && o_par_rdata == 32'h0000_0000))
		else $error("unmapped read not refused");

	pos_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rd_only && a_pos2) |=> o_par_rdata == $past(pos_two))
		else $error("position read mismatch");

endmodule

//--- logic/capture_pkg.sv
// Function
// - two independent channels, each with own pin
// - edge select 0 falling, 1 rising, immediate
// - start/stop 0 cancel, 1 once, 2 continuous
// - single-shot latches first edge, then stops
// - continuous latches every edge until cancelled
// - status bit0 channel one, bit1 channel two
// - latched position is signed 32-bit value
// - reference change recomputes stored positions
// - 16-bit event counter, cleared on activation, or loaded with 1 if a running channel sees an edge in that cycle
package capture_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int REG_W  = 16;
	localparam int POS_W  = 32;
	localparam int CNT_W  = 16;

	// ------------------------------------------------------------
	// parameter addresses
	// ------------------------------------------------------------
	localparam logic [15:0] STATUS_ADDR = 16'h0a02;
	localparam logic [15:0] EDGE1_ADDR  = 16'h0a04;
	localparam logic [15:0] EDGE2_ADDR  = 16'h0a06;
	localparam logic [15:0] START1_ADDR = 16'h0a08;
	localparam logic [15:0] START2_ADDR = 16'h0a0a;
	localparam logic [15:0] POS1_ADDR   = 16'h0a0c;
	localparam logic [15:0] POS2_ADDR   = 16'h0a0e;
	localparam logic [15:0] COUNT1_ADDR = 16'h0a10;
	localparam logic [15:0] COUNT2_ADDR = 16'h0a12;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int          STATUS_ONE_BIT = 0;
	localparam int          STATUS_TWO_BIT = 1;
	localparam logic        EDGE_FALL      = 1'b0;
	localparam logic        EDGE_RISE      = 1'b1;
	localparam logic        EDGE_RESET     = 1'b0;
	localparam logic [15:0] MODE_MAX       = 16'h0002;
	localparam logic [15:0] CNT_ONE        = 16'h0001;
	localparam logic [15:0] CNT_ZERO       = 16'h0000;

	// ------------------------------------------------------------
	// channel run modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_STOP = 2'b00,
		MODE_ONCE = 2'b01,
		MODE_CONT = 2'b10
	} cap_mode_t;

endpackage

//--- logic/capture_channel.sv
`timescale 1ns/1ps
module capture_channel (
	input  wire logic                   i_clk_sys,    // system clock
	input  wire logic                   i_rst,        // async reset, high
	input  wire logic                   i_trig,       // capture input pin
	input  wire logic                   i_edge_rise,  // 1 rising, 0 falling
	input  wire logic                   i_start,      // start/stop write pulse
	input  wire capture_pkg::cap_mode_t i_start_mode, // mode written
	input  wire logic signed [31:0]     i_motor_pos,  // live motor position
	input  wire logic                   i_ref_adjust, // reference redefined pulse
	input  wire logic signed [31:0]     i_ref_delta,  // new minus old reference
	output logic signed [31:0]          o_pos,        // latched position
	output logic [15:0]                 o_count,      // capture event count
	output logic                        o_captured,   // captured since start
	output capture_pkg::cap_mode_t      o_mode        // current run mode
);

	logic trig_meta;
	logic trig_sync;
	logic trig_prev;
	logic [2:0] warm;
	capture_pkg::cap_mode_t next_mode;

	// edge detection on the synchronised pin
	wire rise    = trig_sync & ~trig_prev;
	wire fall    = ~trig_sync & trig_prev;
	wire edge_ok = (i_edge_rise == capture_pkg::EDGE_RISE) ? rise : fall;
	// history trusted only once every stage holds a sampled pin level,
	// so a pin idling high through reset gives no false rising edge
	wire hist_ok = warm[2];
	wire hit     = (o_mode != capture_pkg::MODE_STOP) & edge_ok & hist_ok;

	// mode sequencing
	always_comb begin
		if (i_start)
			next_mode = i_start_mode;
		else if (hit && o_mode == capture_pkg::MODE_ONCE)
			next_mode = capture_pkg::MODE_STOP;
		else
			next_mode = o_mode;
	end

	// two-stage synchroniser and edge history
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
			trig_prev <= 1'b0;
			warm      <= 3'b000;
		end else begin
			trig_meta <= i_trig;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
			warm      <= {warm[1:0], 1'b1};
		end
	end

	// mode, counter and status flag; an edge in the start cycle counts only if the channel was already running
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_mode     <= capture_pkg::MODE_STOP;
			o_count    <= capture_pkg::CNT_ZERO;
			o_captured <= 1'b0;
		end else begin
			o_mode <= next_mode;
			if (i_start) begin
				o_count    <= hit ? capture_pkg::CNT_ONE : capture_pkg::CNT_ZERO;
				o_captured <= hit;
			end else if (hit) begin
				o_count    <= o_count + capture_pkg::CNT_ONE;
				o_captured <= 1'b1;
			end
		end
	end

	// position latch; a fresh capture wins over a recompute
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			o_pos <= 32'sh0000_0000;
		else if (hit)
			o_pos <= i_motor_pos;
		else if (i_ref_adjust)
			o_pos <= o_pos + i_ref_delta;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	once_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(hit && !i_start && o_mode == capture_pkg::MODE_ONCE)
		|=> o_mode == capture_pkg::MODE_STOP)
		else $error("single-shot channel kept running");

	cont_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!i_start && o_mode == capture_pkg::MODE_CONT)
		|=> o_mode == capture_pkg::MODE_CONT)
		else $error("continuous channel stopped without cancel");

	count_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(hit && !i_start) |=> o_count == $past(o_count) + capture_pkg::CNT_ONE)
		else $error("counter did not step on capture");

	start_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_start && !hit) |=> (o_count == capture_pkg::CNT_ZERO && !o_captured))
		else $error("start did not clear counter and flag");

	pos_latch_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		hit |=> o_pos == $past(i_motor_pos))
		else $error("position not latched on edge");

	recalc_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ref_adjust && !hit) |=> o_pos == $past(o_pos) + $past(i_ref_delta))
		else $error("position not recomputed");

	edge_sel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(hit && i_edge_rise) |-> ($past(i_trig, 2) && !$past(i_trig, 3)))
		else $error("rising capture without rising pin");

	edge_fall_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(hit && !i_edge_rise) |-> (!$past(i_trig, 2) && $past(i_trig, 3)))
		else $error("falling capture without falling pin");

endmodule

//--- testbench/trigger_source.sv
`timescale 1ns/1ps
module trigger_source (
	input  wire logic       i_clk_sys, // system clock
	input  wire logic [1:0] i_level,   // requested pin levels
	input  wire logic [1:0] i_lag,     // answer delay in cycles
	output logic            o_pin_one, // capture input one
	output logic            o_pin_two  // capture input two
);
	logic [7:0] hist = 8'h00;
	logic [1:0] lagged;

	// ------------------------------------------------------------
	// delay line so edges can arrive promptly or slowly
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		hist <= {hist[5:0], i_level};
	end

	// each pin is driven on its own line, with no coupling
	assign lagged    = (i_lag == 2'h0) ? i_level : hist[2 * i_lag - 2 +: 2];
	assign o_pin_one = lagged[0];
	assign o_pin_two = lagged[1];
endmodule

//--- testbench/motor_position_capture_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module motor_position_capture_bench;
	typedef struct {
		int ch; logic [15:0] edge_sel; logic [15:0] mode; logic [1:0] lag; int n;
		logic [31:0] base; logic [15:0] exp_cnt; logic [31:0] exp_pos;
	} row_t;

	logic               i_clk_sys    = 1'b0;
	logic               i_rst        = 1'b1;
	logic signed [31:0] i_motor_pos  = 32'h00000000;
	logic               i_ref_adjust = 1'b0;
	logic signed [31:0] i_ref_delta  = 32'h00000000;
	logic [15:0]        i_par_addr   = 16'h0000;
	logic               i_par_wr     = 1'b0;
	logic               i_par_rd     = 1'b0;
	logic [31:0]        i_par_wdata  = 32'h00000000;
	logic [1:0]         level        = 2'h0;
	logic [1:0]         lag          = 2'h0;
	logic               pin_one;
	logic               pin_two;
	logic [31:0]        o_par_rdata;
	logic               o_par_ack;
	logic               o_par_err;
	int                 n_errors        = 0;
	int                 samples_checked = 0;
	row_t               r;
	row_t rows [5] = '{
		'{0, 16'h0001, 16'h0001, 2'h0, 2, 32'h00001000, 16'h0001, 32'h00001000},
		'{0, 16'h0000, 16'h0002, 2'h2, 3, 32'h00002000, 16'h0003, 32'h00002028},
		'{1, 16'h0001, 16'h0002, 2'h1, 2, 32'hfffff000, 16'h0002, 32'hfffff010},
		'{1, 16'h0000, 16'h0001, 2'h3, 2, 32'h00003000, 16'h0001, 32'h00003008},
		'{0, 16'h0000, 16'h0001, 2'h1, 1, 32'h7ffffff0, 16'h0001, 32'h7ffffff8}};

	always #5 i_clk_sys = ~i_clk_sys;

	motor_position_capture motor_position_capture_inst (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_first_trigger_pin(pin_one),
		.i_second_trigger_pin(pin_two), .i_motor_pos(i_motor_pos),
		.i_ref_adjust(i_ref_adjust), .i_ref_delta(i_ref_delta), .i_par_addr(i_par_addr),
		.i_par_wr(i_par_wr), .i_par_rd(i_par_rd), .i_par_wdata(i_par_wdata),
		.o_par_rdata(o_par_rdata), .o_par_ack(o_par_ack), .o_par_err(o_par_err));

	trigger_source trigger_source_inst (
		.i_clk_sys(i_clk_sys), .i_level(level), .i_lag(lag),
		.o_pin_one(pin_one), .o_pin_two(pin_two));

	// ------------------------------------------------------------
	// compare, report and parameter port tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("errors %0d, checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle request pulse, then bounded wait for the answer
	task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int i;
		@(negedge i_clk_sys);
		i_par_addr  = a;
		i_par_wdata = d;
		i_par_wr    = w;
		i_par_rd    = !w;
		@(negedge i_clk_sys);
		i_par_wr = 1'b0;
		i_par_rd = 1'b0;
		for (i = 0; i < 4 && o_par_ack !== 1'b1; i++) begin
			@(negedge i_clk_sys);
		end
		if (i == 4) begin
			n_errors++;
			end_of_test();
		end
		q = o_par_rdata;
		e = o_par_err;
	endtask

	task automatic wreg(input logic [15:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] q;
		logic        e;
		access(1'b1, a, d, q, e);
		`CHK(e, exp_err);
	endtask

	task automatic rreg(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] q;
		logic        e;
		access(1'b0, a, 32'h00000000, q, e);
		`CHK(q, exp);
		`CHK(e, exp_err);
	endtask

	// pulses: motor position marks each rising and falling phase apart
	task automatic pulses(input int ch, input int n, input logic [31:0] base);
		for (int k = 0; k < n; k++) begin
			for (int ph = 0; ph < 2; ph++) begin
				@(negedge i_clk_sys);
				i_motor_pos = 32'(base + k * 16 + ph * 8);
				level[ch]   = (ph == 0);
				repeat (9) @(negedge i_clk_sys);
			end
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rst = 1'b0;
		// table cases: edge, mode and lag per channel
		foreach (rows[j]) begin
			r = rows[j];
			lag = r.lag;
			wreg(capture_pkg::START1_ADDR, 32'h0, 1'b0);
			wreg(capture_pkg::START2_ADDR, 32'h0, 1'b0);
			wreg(capture_pkg::EDGE1_ADDR + 16'(2 * r.ch), 32'(r.edge_sel), 1'b0);
			rreg(capture_pkg::EDGE1_ADDR + 16'(2 * r.ch), 32'(r.edge_sel), 1'b0);
			wreg(capture_pkg::START1_ADDR + 16'(2 * r.ch), 32'(r.mode), 1'b0);
			pulses(r.ch, r.n, r.base);
			rreg(capture_pkg::STATUS_ADDR, 32'(1 << r.ch), 1'b0);
			rreg(capture_pkg::POS1_ADDR + 16'(2 * r.ch), r.exp_pos, 1'b0);
			rreg(capture_pkg::COUNT1_ADDR + 16'(2 * r.ch), 32'(r.exp_cnt), 1'b0);
		end
		// reference redefined: stored position follows
		@(negedge i_clk_sys);
		i_ref_delta  = -32'sd16;
		i_ref_adjust = 1'b1;
		@(negedge i_clk_sys);
		i_ref_adjust = 1'b0;
		rreg(capture_pkg::POS1_ADDR, 32'h7fffffe8, 1'b0);
		rreg(capture_pkg::POS2_ADDR, 32'h00002ff8, 1'b0);
		// refused accesses change nothing
		wreg(capture_pkg::EDGE1_ADDR, 32'h2, 1'b1);
		rreg(capture_pkg::EDGE1_ADDR, 32'h0, 1'b0);
		wreg(capture_pkg::START1_ADDR, 32'h3, 1'b1);
		wreg(capture_pkg::STATUS_ADDR, 32'h0, 1'b1);
		wreg(capture_pkg::POS1_ADDR, 32'h0, 1'b1);
		rreg(16'h0a00, 32'h0, 1'b1);
		// independence, cancel and restart clearing
		wreg(capture_pkg::EDGE1_ADDR, 32'h1, 1'b0);
		wreg(capture_pkg::START1_ADDR, 32'h2, 1'b0);
		pulses(1, 1, 32'h00000010);
		rreg(capture_pkg::COUNT1_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::STATUS_ADDR, 32'h0, 1'b0);
		pulses(0, 1, 32'h00000100);
		wreg(capture_pkg::EDGE1_ADDR, 32'h0, 1'b0);
		pulses(0, 1, 32'h00000200);
		rreg(capture_pkg::POS1_ADDR, 32'h00000208, 1'b0);
		rreg(capture_pkg::COUNT1_ADDR, 32'h2, 1'b0);
		wreg(capture_pkg::START1_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::STATUS_ADDR, 32'h0, 1'b0);
		pulses(0, 1, 32'h00000300);
		rreg(capture_pkg::COUNT1_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::POS1_ADDR, 32'h00000208, 1'b0);
		// reset in mid-run returns register defaults, from a non-default state
		wreg(capture_pkg::EDGE1_ADDR, 32'h1, 1'b0);
		wreg(capture_pkg::START1_ADDR, 32'h2, 1'b0);
		pulses(0, 1, 32'h00000400);
		rreg(capture_pkg::COUNT1_ADDR, 32'h1, 1'b0);
		@(negedge i_clk_sys);
		i_rst = 1'b1;
		repeat (3) @(negedge i_clk_sys);
		i_rst = 1'b0;
		rreg(capture_pkg::EDGE1_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::START1_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::STATUS_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::COUNT1_ADDR, 32'h0, 1'b0);
		rreg(capture_pkg::POS1_ADDR, 32'h0, 1'b0);
		end_of_test();
	end
endmodule
